/* File: src/wdtc_pkg.sv */
// Package: offsets, field positions, reset values and counts of the watchdog
package wdtc_pkg;
  // Device I/O offsets on the 8-bit bus
  localparam logic [3:0] IO_CHAIN_FIRST = 4'h0;
  localparam logic [3:0] IO_CHAIN_SECOND = 4'h1;
  localparam logic [3:0] IO_PULSE_WIDTH = 4'h2;
  localparam logic [3:0] IO_MODE = 4'h3;
  localparam logic [3:0] IO_ENABLE = 4'h7;
  localparam logic [3:0] IO_CLKSEL = 4'hc;
  localparam logic [3:0] IO_CONTROL = 4'hf;
  // Circuit control byte fields
  localparam int CTL_WDG_EN = 0;
  localparam int CTL_SLOW_CLK = 4;
  localparam int CTL_BTN_EN = 5;
  localparam logic [7:0] CTL_START = 8'h01;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // Counter control byte fields
  localparam int CB_SEL_HI = 7;
  localparam int CB_SEL_LO = 6;
  localparam int CB_RW_HI = 5;
  localparam int CB_RW_LO = 4;
  localparam int CB_MODE_HI = 2;
  localparam int CB_MODE_LO = 1;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] RW_LSB = 2'h1;
  localparam logic [1:0] RW_MSB = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [1:0] MODE_RATE = 2'h2;
  localparam logic [1:0] MODE_SQUARE = 2'h3;
  localparam logic [7:0] CB_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // Counter clock: host clock divided by sixteen; fast pulse clock by two
  localparam int DIV_COUNTER = 16;
  localparam int DIV_FAST = 2;
  localparam logic [3:0] PRESC_LAST = 4'(DIV_COUNTER - 1);
  localparam logic [3:0] PRESC_RESET = 4'h0;
  // Figures of the timing ranges, for reference by software
  localparam real TIMEOUT_MIN_US = 2.0;
  localparam real TIMEOUT_MAX_S = 2060.0;
  localparam real PULSE_MIN_NS = 120.0;
  localparam real PULSE_MAX_MS = 31.0;
  // Host APB register offsets
  localparam logic [11:0] APB_CMD = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam int CMD_WDATA_LO = 8;
  localparam int CMD_WRITE = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_WARN = 1;
  localparam int ST_RDATA_LO = 8;
endpackage : wdtc_pkg

/* File: src/wdtc_if.sv */
// Interface: 8-bit I/O bus and warning line between host and watchdog
`timescale 1ns/100ps
interface wdtc_if;
  logic [3:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic io_rack;
  logic warn_irq;

  modport dev (
    input io_addr, io_wdata, io_wr, io_rd,
    output io_rdata, io_rack, warn_irq
  );
  modport host (
    output io_addr, io_wdata, io_wr, io_rd,
    input io_rdata, io_rack, warn_irq
  );
endinterface : wdtc_if

/* File: src/wdtc_device.sv */
// Watchdog device: counter chain, reset pulse, enable and control registers
`timescale 1ns/100ps
module wdtc_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host side
  wdtc_if.dev bus,
  // Board pins
  input wire logic button_n,
  output logic wdg_reset,
  output logic wdg_reset_n
);

  typedef struct packed {
    logic [3:0] presc;
    logic [2:0][7:0] mode;
    logic [2:0][15:0] load;
    logic [2:0][15:0] cnt;
    logic [2:0] wr_hi;
    logic [2:0] rd_hi;
    logic [2:0] loaded;
    logic [7:0] ctl;
    logic sq_out;
    logic warn;
    logic pulse;
    logic [2:0] sync;
    logic btn;
    logic [7:0] rdata;
    logic rack;
  } wdtc_dev_t;

  wdtc_dev_t s_r;
  wdtc_dev_t s_nxt;

  logic tick;
  logic tick_fast;
  logic pulse_tick;
  logic rise0;
  logic tc1;
  logic press;
  logic trigger;
  logic [1:0] sel;
  logic [1:0] rw;
  logic commit;
  logic [15:0] cval;

  // Next state of the whole device
  always_comb begin
    s_nxt = s_r;
    tick = 1'b0;
    tick_fast = 1'b0;
    pulse_tick = 1'b0;
    rise0 = 1'b0;
    tc1 = 1'b0;
    press = 1'b0;
    trigger = 1'b0;
    sel = 2'h0;
    rw = 2'h0;
    commit = 1'b0;
    cval = wdtc_pkg::CNT_RESET;
    s_nxt.rack = 1'b0;

    // Prescaler for the counter clocks
    tick = (s_r.presc == wdtc_pkg::PRESC_LAST);
    tick_fast = s_r.presc[0]; // Every second host clock
    s_nxt.presc = s_r.presc + 4'h1;
    pulse_tick = s_r.ctl[wdtc_pkg::CTL_SLOW_CLK] ? tick : tick_fast;

    // Pushbutton: three flops, a change counts once stages 2 and 3 agree
    s_nxt.sync = {s_r.sync[1:0], button_n};
    if (s_r.sync[2] == s_r.sync[1]) begin
      s_nxt.btn = s_r.sync[2];
      press = s_r.btn && !s_r.sync[2] &&
              s_r.ctl[wdtc_pkg::CTL_BTN_EN];
    end

    // First chain counter, square wave, recycles on its own
    if (s_r.ctl[wdtc_pkg::CTL_WDG_EN] && s_r.loaded[0] && tick &&
        s_r.mode[0][wdtc_pkg::CB_MODE_HI:wdtc_pkg::CB_MODE_LO] ==
        wdtc_pkg::MODE_SQUARE) begin
      if (s_r.cnt[0] == 16'h0002 || s_r.cnt[0] == 16'h0001) begin
        s_nxt.cnt[0] = s_r.load[0];
        s_nxt.sq_out = !s_r.sq_out;
        rise0 = !s_r.sq_out;
      end else begin
        s_nxt.cnt[0] = s_r.cnt[0] - 16'h0002;
      end
    end

    // Second chain counter, clocked by the first one's rising edge
    if (rise0 && s_r.loaded[1] &&
        s_r.mode[1][wdtc_pkg::CB_MODE_HI:wdtc_pkg::CB_MODE_LO] ==
        wdtc_pkg::MODE_RATE) begin
      if (s_r.cnt[1] == 16'h0001) begin
        s_nxt.cnt[1] = s_r.load[1];
        tc1 = 1'b1;
      end else begin
        s_nxt.cnt[1] = s_r.cnt[1] - 16'h0001;
      end
    end

    // Pulse counter: runs only while a triggered pulse is in progress
    if (s_r.pulse && pulse_tick) begin
      if (s_r.cnt[2] == 16'h0001) begin
        s_nxt.pulse = 1'b0;
      end else begin
        s_nxt.cnt[2] = s_r.cnt[2] - 16'h0001;
      end
    end
    // A new trigger is ignored while a pulse runs, so one pulse per event
    trigger = tc1 || press;
    if (trigger && !s_r.pulse) begin
      s_nxt.pulse = 1'b1;
      s_nxt.cnt[2] = s_r.load[2];
    end

    // Host reads
    if (bus.io_rd) begin
      s_nxt.rack = 1'b1;
      s_nxt.rdata = 8'h00;
      unique case (bus.io_addr)
        wdtc_pkg::IO_CHAIN_FIRST, wdtc_pkg::IO_CHAIN_SECOND,
        wdtc_pkg::IO_PULSE_WIDTH: begin
          sel = bus.io_addr[1:0];
          s_nxt.rdata = s_r.rd_hi[sel] ? s_r.cnt[sel][15:8] :
                        s_r.cnt[sel][7:0];
          if (s_r.mode[sel][wdtc_pkg::CB_RW_HI:wdtc_pkg::CB_RW_LO] ==
              wdtc_pkg::RW_BOTH) begin
            s_nxt.rd_hi[sel] = !s_r.rd_hi[sel];
          end
        end
        wdtc_pkg::IO_ENABLE: begin
          s_nxt.ctl[wdtc_pkg::CTL_WDG_EN] = 1'b0;
        end
        wdtc_pkg::IO_CLKSEL: begin
          s_nxt.ctl[wdtc_pkg::CTL_SLOW_CLK] = 1'b0;
        end
        wdtc_pkg::IO_CONTROL: begin
          s_nxt.rdata = s_r.ctl;
        end
        default: begin
          s_nxt.rdata = 8'h00; // Unused locations read zero
        end
      endcase
    end

    // Host writes
    if (bus.io_wr) begin
      unique case (bus.io_addr)
        wdtc_pkg::IO_CHAIN_FIRST, wdtc_pkg::IO_CHAIN_SECOND,
        wdtc_pkg::IO_PULSE_WIDTH: begin
          sel = bus.io_addr[1:0];
          rw = s_r.mode[sel][wdtc_pkg::CB_RW_HI:wdtc_pkg::CB_RW_LO];
          cval = s_r.load[sel];
          if (rw == wdtc_pkg::RW_LSB ||
              (rw == wdtc_pkg::RW_BOTH && !s_r.wr_hi[sel])) begin
            cval[7:0] = bus.io_wdata;
          end else begin
            cval[15:8] = bus.io_wdata;
          end
          commit = (rw != wdtc_pkg::RW_BOTH) || s_r.wr_hi[sel];
          if (rw == wdtc_pkg::RW_BOTH) begin
            s_nxt.wr_hi[sel] = !s_r.wr_hi[sel];
          end
          s_nxt.load[sel] = cval;
          // Refresh takes effect at once, chain counters restart from new value; pulse count does not
          if (commit && rw != 2'h0) begin
            s_nxt.loaded[sel] = 1'b1;
            if (sel != 2'h2) begin
              s_nxt.cnt[sel] = cval;
            end
            // Square output starts high, so the second counter first
            // steps one whole period after the load
            if (sel == 2'h0) begin
              s_nxt.sq_out = 1'b1;
            end
            if (sel == 2'h1) begin
              s_nxt.warn = 1'b0; // Refresh answers the warning
            end
          end
        end
        wdtc_pkg::IO_MODE: begin
          sel = bus.io_wdata[wdtc_pkg::CB_SEL_HI:wdtc_pkg::CB_SEL_LO];
          // Latch and readback commands are not supported: ignored
          if (sel != wdtc_pkg::SEL_READBACK &&
              bus.io_wdata[wdtc_pkg::CB_RW_HI:wdtc_pkg::CB_RW_LO] != 2'h0)
          begin
            s_nxt.mode[sel] = bus.io_wdata;
            s_nxt.loaded[sel] = 1'b0;
            s_nxt.wr_hi[sel] = 1'b0;
            s_nxt.rd_hi[sel] = 1'b0;
          end
        end
        wdtc_pkg::IO_ENABLE: begin
          s_nxt.ctl[wdtc_pkg::CTL_WDG_EN] = 1'b1;
        end
        wdtc_pkg::IO_CLKSEL: begin
          s_nxt.ctl[wdtc_pkg::CTL_SLOW_CLK] = 1'b1;
        end
        wdtc_pkg::IO_CONTROL: begin
          s_nxt.ctl = bus.io_wdata; // Value 01 starts the watchdog
        end
        default: begin
          s_nxt.ctl = s_r.ctl; // Unused locations ignore writes
        end
      endcase
    end

    // Warning when the second counter reaches its last period; set wins
    if (rise0 && s_r.cnt[1] == 16'h0002 && s_r.loaded[1]) begin
      s_nxt.warn = 1'b1;
    end
    if (tc1) begin
      s_nxt.warn = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{presc: wdtc_pkg::PRESC_RESET,
               mode: {3{wdtc_pkg::CB_RESET}},
               load: {3{wdtc_pkg::CNT_RESET}},
               cnt: {3{wdtc_pkg::CNT_RESET}},
               wr_hi: 3'h0, rd_hi: 3'h0, loaded: 3'h0,
               ctl: wdtc_pkg::CTL_RESET,
               sq_out: 1'b0, warn: 1'b0, pulse: 1'b0,
               sync: 3'h7, btn: 1'b1, rdata: 8'h00, rack: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs; both reset lines come from the one pulse flop
  assign wdg_reset = s_r.pulse;
  assign wdg_reset_n = !s_r.pulse;
  assign bus.io_rdata = s_r.rdata;
  assign bus.io_rack = s_r.rack;
  assign bus.warn_irq = s_r.warn;

endmodule : wdtc_device

/* File: src/wdtc_host.sv */
// Host end: APB command registers driving the 8-bit I/O bus
`timescale 1ns/100ps
module wdtc_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device side
  wdtc_if.host bus
);

  typedef struct packed {
    logic busy;
    logic wait_rd;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
  } wdtc_host_t;

  wdtc_host_t s_r;
  wdtc_host_t s_nxt;

  logic access;
  logic cmd_hit;
  logic st_hit;

  // Decode; a command write while busy is stalled, not dropped
  always_comb begin
    cmd_hit = (paddr == wdtc_pkg::APB_CMD);
    st_hit = (paddr == wdtc_pkg::APB_STATUS);
    pready = !(psel && penable && pwrite && cmd_hit && s_r.busy);
    access = psel && penable && pready;
    pslverr = psel && penable && !cmd_hit && !st_hit;
    prdata = 32'h0000_0000;
    if (psel && st_hit) begin
      prdata[wdtc_pkg::ST_BUSY] = s_r.busy;
      prdata[wdtc_pkg::ST_WARN] = bus.warn_irq; // Polled warning
      prdata[wdtc_pkg::ST_RDATA_LO +: 8] = s_r.rdata;
    end
  end

  // Command sequencing: one strobe cycle, reads wait for the answer
  always_comb begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    if (access && pwrite && cmd_hit) begin
      // Software orders refreshes through these commands
      s_nxt.addr = pwdata[3:0];
      s_nxt.wdata = pwdata[wdtc_pkg::CMD_WDATA_LO +: 8];
      s_nxt.wr = pwdata[wdtc_pkg::CMD_WRITE];
      s_nxt.rd = !pwdata[wdtc_pkg::CMD_WRITE];
      s_nxt.busy = !pwdata[wdtc_pkg::CMD_WRITE];
      s_nxt.wait_rd = !pwdata[wdtc_pkg::CMD_WRITE];
    end
    if (s_r.wait_rd && bus.io_rack) begin
      s_nxt.rdata = bus.io_rdata;
      s_nxt.busy = 1'b0;
      s_nxt.wait_rd = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{busy: 1'b0, wait_rd: 1'b0, addr: 4'h0, wdata: 8'h00,
               wr: 1'b0, rd: 1'b0, rdata: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.io_addr = s_r.addr;
  assign bus.io_wdata = s_r.wdata;
  assign bus.io_wr = s_r.wr;
  assign bus.io_rd = s_r.rd;

endmodule : wdtc_host

/* File: testbench/wdtc_asserts.sv */
// Checker: link handshake, warning and reset pin relations
`timescale 1ns/100ps
module wdtc_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link and pins
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_rack,
  input wire logic warn_irq,
  input wire logic wdg_reset,
  input wire logic wdg_reset_n
);
  // One clock domain throughout
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Read steps: request, then answer
  sequence rd_req_s;
    io_rd;
  endsequence
  sequence rd_ans_s;
    io_rack;
  endsequence
  property pulse_p;
    $rose(wdg_reset) |-> ##[1:60] !wdg_reset;
  endproperty
  // Warning only drops on timeout or a host access
  property warn_p;
    $fell(warn_irq) |-> wdg_reset || $past(io_wr) || $past(io_rd);
  endproperty
  rd_answer_a: assert property (rd_req_s |=> rd_ans_s)
    else $error("read not answered");
  ack_cause_a: assert property (io_rack |-> $past(io_rd))
    else $error("stray answer");
  strobe_excl_a: assert property (!(io_rd && io_wr))
    else $error("read and write together");
  wr_pulse_a: assert property (io_wr |=> !io_wr)
    else $error("write strobe too long");
  rdata_hold_a: assert property (!io_rack |-> $stable(io_rdata))
    else $error("read data moved");
  pins_pair_a: assert property (wdg_reset_n == !wdg_reset)
    else $error("reset pins disagree");
  pulse_end_a: assert property (pulse_p)
    else $error("reset pulse too long");
  warn_clear_a: assert property (warn_p)
    else $error("warning dropped without cause");
endmodule : wdtc_asserts

/* File: testbench/watchdog_timeout_control_tb.sv */
// Testbench: APB-driven host joined to the watchdog device
`timescale 1ns/100ps
module watchdog_timeout_control_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, err_seen, wdg_reset, wdg_reset_n;
  logic button_n = 1'b1;
  logic [7:0] b;
  int fail_count = 0;
  int n_tests = 0;
  int n, w;
  wdtc_if lnk ();
  wdtc_host wdtc_host_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(lnk.host));
  wdtc_device wdtc_device_inst (.clk(clk), .rst_n(rst_n), .bus(lnk.dev),
    .button_n(button_n), .wdg_reset(wdg_reset), .wdg_reset_n(wdg_reset_n));
  wdtc_asserts wdtc_asserts_inst (.clk(clk), .rst_n(rst_n),
    .io_wr(lnk.io_wr), .io_rd(lnk.io_rd), .io_rdata(lnk.io_rdata),
    .io_rack(lnk.io_rack), .warn_irq(lnk.warn_irq),
    .wdg_reset(wdg_reset), .wdg_reset_n(wdg_reset_n));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // APB transfer; pready and the answer are taken at one rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 100 && pready !== 1'b1; i++) begin
      @(posedge clk);
    end
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    // Idle edge, so the next setup never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  // Device byte write and read through the command register
  task automatic io_w(input logic [3:0] off, input logic [7:0] v);
    logic [31:0] r;
    apb(1'b1, wdtc_pkg::APB_CMD, 32'({1'b1, v, 4'h0, off}), r);
  endtask : io_w
  task automatic io_r(input logic [3:0] off, output logic [7:0] v);
    logic [31:0] r;
    int i;
    apb(1'b1, wdtc_pkg::APB_CMD, 32'({1'b0, 8'h00, 4'h0, off}), r);
    r = 32'h1;
    for (i = 0; i < 20 && r[wdtc_pkg::ST_BUSY] !== 1'b0; i++) begin
      apb(1'b0, wdtc_pkg::APB_STATUS, 32'h0, r);
    end
    if (i == 20) begin
      fail_count++;
      report_and_stop();
    end
    v = r[15:8];
  endtask : io_r
  task automatic load(input logic [3:0] off, input logic [7:0] v);
    io_w(off, v);
    io_w(off, 8'h00);
  endtask : load
  // Cycles until warning or reset pin reaches lvl, bounded
  task automatic wait_for(input bit wn, input logic lvl, input int lim,
      output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(negedge clk);
      if ((wn ? lnk.warn_irq : wdg_reset) === lvl) break;
    end
    @(posedge clk);
  endtask : wait_for
  // Chain of 4 and 3 gives a 192-cycle timeout
  task automatic t_timeout();
    io_r(wdtc_pkg::IO_ENABLE, b);
    chk("disable read", b, 8'h00);
    io_w(wdtc_pkg::IO_MODE, 8'h36);
    io_w(wdtc_pkg::IO_MODE, 8'h74);
    io_w(wdtc_pkg::IO_MODE, 8'hb4);
    load(wdtc_pkg::IO_CHAIN_FIRST, 8'h04);
    load(wdtc_pkg::IO_CHAIN_SECOND, 8'h03);
    load(wdtc_pkg::IO_PULSE_WIDTH, 8'h02);
    io_w(wdtc_pkg::IO_CONTROL, wdtc_pkg::CTL_START);
    io_r(wdtc_pkg::IO_CONTROL, b);
    chk("control", b, 8'h01);
    wait_for(1'b1, 1'b1, 400, n);
    wait_for(1'b0, 1'b1, 400, w);
    chk("warn lead", w >= 62 && w <= 67, 1);
    chk("timeout", n + w >= 150 && n + w <= 200, 1);
    chk("low pin", wdg_reset_n, 1'b0);
    wait_for(1'b0, 1'b0, 300, w);
    chk("fast pulse", w >= 1 && w <= 5, 1);
    wait_for(1'b0, 1'b1, 400, n);
    chk("period", n + w >= 186 && n + w <= 194, 1);
    $display("done timeout");
  endtask : t_timeout
  // Refresh second counter in time, then stop refreshing
  task automatic t_refresh();
    wait_for(1'b0, 1'b0, 300, w);
    repeat (4) begin
      wait_for(1'b0, 1'b1, 100, n);
      chk("no reset", n, 100);
      // Spacing near 110 cycles, well inside the 192-cycle chain
      io_w(wdtc_pkg::IO_MODE, 8'h74);
      load(wdtc_pkg::IO_CHAIN_SECOND, 8'h03);
    end
    wait_for(1'b0, 1'b1, 300, n);
    chk("late reset", n >= 120 && n <= 200, 1);
    // Refresh only in answer to the warning, as a service routine would
    wait_for(1'b1, 1'b1, 300, n);
    chk("warn seen", n < 300, 1);
    io_w(wdtc_pkg::IO_MODE, 8'h74);
    load(wdtc_pkg::IO_CHAIN_SECOND, 8'h03);
    @(posedge clk);
    chk("warn cleared", lnk.warn_irq, 1'b0);
    wait_for(1'b0, 1'b1, 100, n);
    chk("isr refresh", n, 100);
    $display("done refresh");
  endtask : t_refresh
  // Enable read halts, enable write resumes
  task automatic t_stop();
    wait_for(1'b0, 1'b0, 300, w);
    io_r(wdtc_pkg::IO_ENABLE, b);
    wait_for(1'b0, 1'b1, 400, n);
    chk("halted", n, 400);
    io_w(wdtc_pkg::IO_ENABLE, 8'h5a);
    wait_for(1'b0, 1'b1, 400, n);
    chk("resumed", n < 200, 1);
    wait_for(1'b0, 1'b0, 300, w);
    io_r(wdtc_pkg::IO_ENABLE, b);
    $display("done stop");
  endtask : t_stop
  // Pushbutton masked, then allowed with slow pulse clock
  task automatic t_button();
    io_w(wdtc_pkg::IO_CONTROL, 8'h00);
    button_n <= 1'b0;
    wait_for(1'b0, 1'b1, 40, n);
    chk("masked", n, 40);
    button_n <= 1'b1;
    repeat (5) @(posedge clk);
    io_w(wdtc_pkg::IO_CONTROL, 8'h30);
    button_n <= 1'b0;
    wait_for(1'b0, 1'b1, 20, n);
    chk("button", n < 20, 1);
    wait_for(1'b0, 1'b0, 300, w);
    chk("slow pulse", w >= 16 && w <= 48, 1);
    button_n <= 1'b1;
    io_r(wdtc_pkg::IO_CLKSEL, b);
    io_r(wdtc_pkg::IO_CONTROL, b);
    chk("clksel", b, 8'h20);
    io_w(wdtc_pkg::IO_CLKSEL, 8'h00);
    io_r(wdtc_pkg::IO_CONTROL, b);
    chk("clksel set", b, 8'h30);
    apb(1'b1, 12'h010, 32'h1, q);
    chk("unmapped", err_seen, 1'b1);
    $display("done button");
  endtask : t_button
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_timeout();
    t_refresh();
    t_stop();
    t_button();
    report_and_stop();
  end
endmodule : watchdog_timeout_control_tb
